/* src/lsr_pkg.sv */
// Shared constants for the light sensor register and threshold logic.
// Assumes a 125 MHz system clock and register addressing over the serial link.
package lsr_pkg;

    // ------------------------------------------------------------
    // Register select values
    // ------------------------------------------------------------
    localparam int SEL_W = 5;
    localparam logic [SEL_W-1:0] REG_CTRL = 5'h00;
    localparam logic [SEL_W-1:0] REG_INTERRUPT_SETUP = 5'h01;
    localparam logic [SEL_W-1:0] REG_PERIOD = 5'h02;
    localparam logic [SEL_W-1:0] REG_LOW0 = 5'h03;
    localparam logic [SEL_W-1:0] REG_LOW1 = 5'h04;
    localparam logic [SEL_W-1:0] REG_LOW2 = 5'h05;
    localparam logic [SEL_W-1:0] REG_HIGH0 = 5'h06;
    localparam logic [SEL_W-1:0] REG_HIGH1 = 5'h07;
    localparam logic [SEL_W-1:0] REG_HIGH2 = 5'h08;
    localparam logic [SEL_W-1:0] REG_RES0 = 5'h14;
    localparam logic [SEL_W-1:0] REG_RES1 = 5'h15;
    localparam logic [SEL_W-1:0] REG_RES2 = 5'h16;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_VALID_BIT = 4;
    localparam int CTRL_FLAG_BIT = 5;
    localparam int INTERRUPT_SETUP_STOP_BIT = 6;
    localparam int INTERRUPT_SETUP_CLR_BIT = 7;
    localparam int CMD_BIT = 7;
    localparam int IRQ_PERSISTENCE_W = 4;
    localparam int LEVEL_W = 20;
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ------------------------------------------------------------
    // Slave address bytes (write form; read form has bit 0 set)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOW = 8'hA8;
    localparam logic [7:0] ADDR_HIGH = 8'h56;
    localparam logic [7:0] ADDR_FLOAT = 8'h34;
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_HIGH = 2'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int STEP_TIME_MS = 5;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STEP_CYCLES_DEF = STEP_TIME_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK} lsr_link_t;

endpackage

/* src/lsr_top.sv */
// Register bank, serial slave and threshold interrupt logic of the light sensor.
// Assumes scl/sda and the strap come from pins; light_sample is the converter
// output on clk_sys; sda and the interrupt line are open drain with pull-ups.
`timescale 1ns/100ps
module lsr_top import lsr_pkg::*; #(
    parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] address_select_pin,
    input wire logic [LEVEL_W-1:0] light_sample,
    output logic irq_n
);

    localparam int STEP_W = $clog2(STEP_CYCLES + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic [1:0] strap_m, strap_s;

    // Two flops per pin; the third scl/sda stage only feeds edge detection
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            strap_m <= 2'h0;
            strap_s <= 2'h0;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
            strap_m <= address_select_pin;
            strap_s <= strap_m;
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] my_addr;

    // Edge and frame condition detection
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
    // Strap picks the address; any code other than low/high is floating
    assign my_addr = (strap_s == STRAP_LOW) ? ADDR_LOW :
                     (strap_s == STRAP_HIGH) ? ADDR_HIGH : ADDR_FLOAT;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic power_reg, power_next, en_reg, en_next, flag_reg, flag_next, valid_reg, valid_next;
    logic stop_reg, stop_next;
    logic [IRQ_PERSISTENCE_W-1:0] irq_persistence_reg, irq_persistence_next, pcnt_reg, pcnt_next;
    logic [7:0] period_reg, period_next;
    logic [LEVEL_W-1:0] low_reg, low_next, high_reg, high_next, res_reg, res_next;
    logic [STEP_W-1:0] step_reg, step_next;
    logic [7:0] per_reg, per_next;

    // ------------------------------------------------------------
    // Serial slave state
    // ------------------------------------------------------------
    lsr_link_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic oe_reg, oe_next, rw_reg, rw_next, first_reg, first_next;
    logic [SEL_W-1:0] addr_reg, addr_next, base_reg, base_next;
    logic wr_stb, wr_data_stb, cmd_stb, rd_stb;
    logic [7:0] rd_byte;

    // Read mux; unmapped selects and fixed-zero bits read zero
    always_comb begin
        rd_byte = 8'h00;
        case (addr_reg)
            REG_CTRL: begin
                rd_byte[CTRL_POWER_BIT] = power_reg;
                rd_byte[CTRL_EN_BIT] = en_reg;
                rd_byte[CTRL_VALID_BIT] = valid_reg;
                rd_byte[CTRL_FLAG_BIT] = flag_reg;
            end
            REG_INTERRUPT_SETUP: begin
                rd_byte[INTERRUPT_SETUP_STOP_BIT] = stop_reg;
                rd_byte[IRQ_PERSISTENCE_W-1:0] = irq_persistence_reg;
            end
            REG_PERIOD: rd_byte = period_reg;
            REG_LOW0: rd_byte = low_reg[7:0];
            REG_LOW1: rd_byte = low_reg[15:8];
            REG_LOW2: rd_byte[3:0] = low_reg[19:16];
            REG_HIGH0: rd_byte = high_reg[7:0];
            REG_HIGH1: rd_byte = high_reg[15:8];
            REG_HIGH2: rd_byte[3:0] = high_reg[19:16];
            REG_RES0: rd_byte = res_reg[7:0];
            REG_RES1: rd_byte = res_reg[15:8];
            REG_RES2: rd_byte[3:0] = res_reg[19:16];
            default: rd_byte = 8'h00;
        endcase
    end

    // Byte framing: sample on scl rise, change sda on scl fall
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        addr_next = addr_reg;
        base_next = base_reg;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (start_seen) begin
            // Repeated start restarts from the stored base
            st_next = ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
            first_next = 1'b1;
            addr_next = base_reg;
        end else if (stop_seen) begin
            st_next = ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (st_reg)
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        sh_next = {sh_reg[6:0], sda_s};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BYTE_BITS) begin
                        cnt_next = 4'h0;
                        if (st_reg == ST_WR) begin
                            st_next = ST_WACK;
                            oe_next = 1'b1;
                            wr_stb = 1'b1;
                        end else if (sh_reg[7:1] == my_addr[7:1]) begin
                            st_next = ST_AACK;
                            oe_next = 1'b1;
                            rw_next = sh_reg[0];
                        end else begin
                            st_next = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            st_next = ST_RD;
                            rd_stb = 1'b1;
                        end else begin
                            st_next = ST_WR;
                            oe_next = 1'b0;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        st_next = ST_WR;
                        oe_next = 1'b0;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == BYTE_BITS) begin
                            st_next = ST_RACK;
                            oe_next = 1'b0;
                            cnt_next = 4'h0;
                        end else begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    // Master nack ends the read
                    if (scl_rise && sda_s) begin
                        st_next = ST_IDLE;
                    end else if (scl_fall) begin
                        st_next = ST_RD;
                        rd_stb = 1'b1;
                    end
                end
                default: st_next = ST_IDLE;
            endcase
        end
        // Load a read byte and step the address
        if (rd_stb) begin
            sh_next = rd_byte;
            oe_next = ~rd_byte[7];
            addr_next = SEL_W'(addr_reg + 1'b1);
            first_next = 1'b0;
        end
        // Only the first byte may be a command; later ones are data
        if (wr_stb) begin
            first_next = 1'b0;
            if (cmd_stb) begin
                base_next = sh_reg[SEL_W-1:0];
                addr_next = sh_reg[SEL_W-1:0];
            end else begin
                addr_next = SEL_W'(addr_reg + 1'b1);
            end
        end
    end

    assign cmd_stb = wr_stb & first_reg & sh_reg[CMD_BIT];
    assign wr_data_stb = wr_stb & ~cmd_stb;

    // Slave registers; the command base survives between transactions
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            addr_reg <= REG_CTRL;
            base_reg <= REG_CTRL;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            addr_reg <= addr_next;
            base_reg <= base_next;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_reg;

    // ------------------------------------------------------------
    // Conversion timing and threshold interrupt
    // ------------------------------------------------------------
    logic run, step_done, cyc_done, out_range, irq_set, int_clr;

    // Period zero holds the timer, since it names no valid integration time
    assign run = power_reg & en_reg & (period_reg != 8'h00);
    assign step_done = run && step_reg == STEP_W'(STEP_CYCLES - 1);
    assign cyc_done = step_done && per_reg == period_reg - 8'h01;
    assign out_range = light_sample <= low_reg || light_sample >= high_reg;
    assign irq_set = cyc_done && (irq_persistence_reg == 4'h0 ||
                     (out_range && 5'(pcnt_reg) + 5'h1 >= 5'(irq_persistence_reg)));
    assign int_clr = wr_data_stb && addr_reg == REG_INTERRUPT_SETUP && sh_reg[INTERRUPT_SETUP_CLR_BIT];

    always_comb begin
        power_next = power_reg;
        en_next = en_reg;
        stop_next = stop_reg;
        irq_persistence_next = irq_persistence_reg;
        period_next = period_reg;
        low_next = low_reg;
        high_next = high_reg;
        res_next = res_reg;
        step_next = step_reg;
        per_next = per_reg;
        // Host writes; only documented fields are kept
        if (wr_data_stb) begin
            case (addr_reg)
                REG_CTRL: begin
                    power_next = sh_reg[CTRL_POWER_BIT];
                    en_next = sh_reg[CTRL_EN_BIT];
                end
                REG_INTERRUPT_SETUP: begin
                    stop_next = sh_reg[INTERRUPT_SETUP_STOP_BIT];
                    irq_persistence_next = sh_reg[IRQ_PERSISTENCE_W-1:0];
                end
                REG_PERIOD: period_next = sh_reg;
                REG_LOW0: low_next[7:0] = sh_reg;
                REG_LOW1: low_next[15:8] = sh_reg;
                REG_LOW2: low_next[19:16] = sh_reg[3:0];
                REG_HIGH0: high_next[7:0] = sh_reg;
                REG_HIGH1: high_next[15:8] = sh_reg;
                REG_HIGH2: high_next[19:16] = sh_reg[3:0];
                default: ;
            endcase
        end
        // One-shot stop beats a host enable in the same cycle
        if (irq_set && stop_reg) begin
            en_next = 1'b0;
        end
        // Flag: hardware set wins over host clear
        flag_next = irq_set ? 1'b1 : (int_clr ? 1'b0 : flag_reg);
        valid_next = (power_reg & en_reg) ? (valid_reg | cyc_done) : 1'b0;
        // Persistence run length
        if (int_clr || (cyc_done && !out_range) || irq_set) begin
            pcnt_next = 4'h0;
        end else if (cyc_done) begin
            pcnt_next = pcnt_reg + 4'h1;
        end else begin
            pcnt_next = pcnt_reg;
        end
        // Integration timer in 5 ms steps
        if (!run) begin
            step_next = '0;
            per_next = 8'h00;
        end else if (step_done) begin
            step_next = '0;
            per_next = cyc_done ? 8'h00 : per_reg + 8'h01;
        end else begin
            step_next = step_reg + 1'b1;
        end
        if (cyc_done) begin
            res_next = light_sample;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            power_reg <= 1'b0;
            en_reg <= 1'b0;
            flag_reg <= 1'b0;
            valid_reg <= 1'b0;
            stop_reg <= 1'b0;
            irq_persistence_reg <= 4'h0;
            pcnt_reg <= 4'h0;
            period_reg <= PERIOD_RST;
            low_reg <= 20'h00000;
            high_reg <= 20'h00000;
            res_reg <= 20'h00000;
            step_reg <= '0;
            per_reg <= 8'h00;
        end else begin
            power_reg <= power_next;
            en_reg <= en_next;
            flag_reg <= flag_next;
            valid_reg <= valid_next;
            stop_reg <= stop_next;
            irq_persistence_reg <= irq_persistence_next;
            pcnt_reg <= pcnt_next;
            period_reg <= period_next;
            low_reg <= low_next;
            high_reg <= high_next;
            res_reg <= res_next;
            step_reg <= step_next;
            per_reg <= per_next;
        end
    end

    // Interrupt line follows the flag, active low for an open-drain pull-up
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~flag_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_pin_follows;
        irq_set |=> !irq_n && flag_reg;
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("irq pin disagrees with flag");

    property p_clear;
        int_clr && !irq_set |=> !flag_reg && irq_n;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not drop flag");

    property p_stop_on_irq;
        irq_set && stop_reg |=> !en_reg && flag_reg;
    endproperty
    a_stop_on_irq: assert property (p_stop_on_irq) else $error("one-shot left converter enabled");

    property p_valid_off;
        !(power_reg && en_reg) |=> !valid_reg;
    endproperty
    a_valid_off: assert property (p_valid_off) else $error("valid set while disabled");

    property p_period_zero;
        period_reg == 8'h00 |-> !cyc_done && !irq_set;
    endproperty
    a_period_zero: assert property (p_period_zero) else $error("cycle ended with zero period");

    property p_command;
        cmd_stb |=> base_reg == $past(sh_reg[SEL_W-1:0]) && addr_reg == base_reg;
    endproperty
    a_command: assert property (p_command) else $error("command byte not loaded");

    property p_irq_persistence_zero;
        cyc_done && irq_persistence_reg == 4'h0 |=> flag_reg && valid_reg;
    endproperty
    a_irq_persistence_zero: assert property (p_irq_persistence_zero) else $error("no interrupt at persistence zero");

    property p_in_range;
        cyc_done && !out_range |=> pcnt_reg == 4'h0;
    endproperty
    a_in_range: assert property (p_in_range) else $error("persistence count not restarted");

    property p_result;
        cyc_done |=> res_reg == $past(light_sample);
    endproperty
    a_result: assert property (p_result) else $error("result not captured");

    property p_single_out;
        cyc_done && out_range && irq_persistence_reg == 4'h1 |=> flag_reg;
    endproperty
    a_single_out: assert property (p_single_out) else $error("single out-of-range result missed");

    property p_data_step;
        wr_data_stb |=> addr_reg == SEL_W'($past(addr_reg) + 1'b1);
    endproperty
    a_data_step: assert property (p_data_step) else $error("address did not step");

endmodule

/* tb/lsr_host.sv */
// Serial host model: start, stop and byte transfers on a 64 ns clock.
// Assumes open-drain data with a pull-up, worked out by the bench.
`timescale 1ns/100ps
module lsr_host (
    output logic scl,
    output logic m_oe,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Idle: clock stands high, data released
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    // One bit; data moves mid low phase, never while scl is high
    task automatic bitx(input logic b, output logic r);
        m_oe = !b;
        #16 scl = 1'b1;
        #16 r = sda;
        #16 scl = 1'b0;
        #16;
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        m_oe = 1'b0;
        #16 scl = 1'b1;
        #32 m_oe = 1'b1;
        #32 scl = 1'b0;
        #16;
    endtask
    // Stop: data rises while clock is high, then clock stays still
    task automatic stop();
        m_oe = 1'b1;
        #16 scl = 1'b1;
        #32 m_oe = 1'b0;
        #32;
    endtask
    // Eight bits msb first, then the ninth; a=0 acknowledges a read
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(a, r);
        k = !r;
    endtask
endmodule

/* tb/light_sensor_register_interrupt_bench.sv */
// Self-checking bench of the sensor register bank and threshold logic.
// Assumes lsr_top with a short integration step and the host model.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module light_sensor_register_interrupt_bench import lsr_pkg::*;;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] address_select_pin = 2'h2;
    logic [19:0] sample = 20'h00000;
    wire scl, m_oe, sda_o, sda_oe, irq_n;
    wire sda = !(sda_oe | m_oe);
    int err_total = 0;
    int n_tests = 0;
    logic k;
    logic [7:0] dev = 8'h34;
    logic [7:0] tab[3] = '{8'hA8, 8'h56, 8'h34};
    logic [3:0] pt[5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hF};

    lsr_top #(.STEP_CYCLES(4)) i_lsr_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
        .light_sample(sample), .irq_n(irq_n));
    lsr_host i_lsr_host (.scl(scl), .m_oe(m_oe), .sda(sda));

    initial forever #4 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Register access over the serial link
    // ------------------------------------------------------------
    // Command byte selects the base; data follows
    task automatic wr(input logic [4:0] a, input logic [7:0] d[$]);
        logic [7:0] x;
        i_lsr_host.start();
        i_lsr_host.xfer(dev, 1'b1, x, k);
        i_lsr_host.xfer({3'h4, a}, 1'b1, x, k);
        foreach (d[i]) i_lsr_host.xfer(d[i], 1'b1, x, k);
        i_lsr_host.stop();
    endtask
    // Read n bytes from a, last one not acknowledged, then compare
    task automatic rc(input logic [4:0] a, input logic [7:0] e[$]);
        logic [7:0] x;
        i_lsr_host.start();
        i_lsr_host.xfer(dev, 1'b1, x, k);
        i_lsr_host.xfer({3'h4, a}, 1'b1, x, k);
        i_lsr_host.start();
        i_lsr_host.xfer(dev | 8'h01, 1'b1, x, k);
        foreach (e[i]) begin
            i_lsr_host.xfer(8'hFF, i == e.size() - 1, x, k);
            `CHK(x, e[i])
        end
        i_lsr_host.stop();
    endtask
    // Bounded wait for the interrupt line; a hang ends the run
    task automatic wirq(output int c);
        c = 0;
        while (irq_n !== 1'b0) begin
            @(negedge clk_sys);
            c++;
            if (c > 4000) begin
                err_total++;
                results();
            end
        end
    endtask
    task automatic results();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int c;
        logic [3:0] p;
        logic [7:0] x;
        logic [19:0] lo, hi;
        void'($urandom(86));
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        `CHK(irq_n, 1'b1)
        `CHK(sda_o, 1'b0)
        rc(REG_CTRL, '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        rc(REG_RES0, '{8'h00, 8'h00, 8'h00});
        // Each strap answers only its own address pair
        for (int s = 0; s < 3; s++) begin
            @(negedge clk_sys) address_select_pin = 2'(s);
            repeat (4) @(negedge clk_sys);
            for (int j = 0; j < 3; j++) begin
                i_lsr_host.start();
                i_lsr_host.xfer(tab[j], 1'b1, x, k);
                i_lsr_host.stop();
                `CHK(k, j == s)
            end
            dev = tab[s];
            rc(REG_PERIOD, '{8'hFF});
        end
        // Limits with bit 7 set in a data byte and junk in fixed-zero bits
        lo = 20'($urandom);
        hi = 20'($urandom);
        lo[7] = 1'b1;
        wr(REG_LOW0, '{lo[7:0], lo[15:8], {4'($urandom), lo[19:16]}, hi[7:0], hi[15:8], {4'hF, hi[19:16]}});
        rc(REG_LOW0, '{lo[7:0], lo[15:8], {4'h0, lo[19:16]}, hi[7:0], hi[15:8], {4'h0, hi[19:16]}});
        wr(REG_CTRL, '{8'hCC});
        wr(REG_RES0, '{8'h5A});
        rc(REG_CTRL, '{8'h00});
        rc(REG_RES0, '{8'h00});
        // Data-first byte lands on the base set earlier
        wr(REG_PERIOD, '{8'h07});
        i_lsr_host.start();
        i_lsr_host.xfer(dev, 1'b1, x, k);
        i_lsr_host.xfer(8'h04, 1'b1, x, k);
        i_lsr_host.stop();
        rc(REG_PERIOD, '{8'h04});
        wr(REG_LOW0, '{8'h00, 8'h00, 8'h08, 8'hFF, 8'hFF, 8'h0F});
        wr(REG_CTRL, '{8'h01});
        // Persistence: one integration is 4 steps of 4 clocks
        for (int t = 0; t < 6; t++) begin
            p = t < 5 ? pt[t] : 4'(2 + $urandom % 14);
            wr(REG_INTERRUPT_SETUP, '{{4'h8, p}});
            `CHK(irq_n, 1'b1)
            @(negedge clk_sys) sample = p == 0 ? 20'h90000 : t == 2 ? 20'hFFFFF : 20'($urandom % 20'h80001);
            wr(REG_CTRL, '{8'h03});
            wirq(c);
            `CHK(4'((c + 24) / 16), p == 0 ? 4'h1 : p)
            rc(REG_CTRL, '{8'h33});
            wr(REG_CTRL, '{8'h01});
        end
        // One-shot stop, result bytes, then clear before any re-enable
        wr(REG_INTERRUPT_SETUP, '{8'hC1});
        lo = 20'($urandom % 20'h80000);
        @(negedge clk_sys) sample = lo;
        wr(REG_CTRL, '{8'h03});
        wirq(c);
        rc(REG_CTRL, '{8'h21, 8'h41});
        rc(REG_RES0, '{lo[7:0], lo[15:8], {4'h0, lo[19:16]}});
        wr(REG_INTERRUPT_SETUP, '{8'hC1});
        `CHK(irq_n, 1'b1)
        rc(REG_CTRL, '{8'h01});
        // Period zero names no valid time, so no cycle may ever end
        wr(REG_PERIOD, '{8'h00});
        wr(REG_CTRL, '{8'h03});
        repeat (1100) @(negedge clk_sys);
        `CHK(irq_n, 1'b1)
        rc(REG_CTRL, '{8'h03});
        results();
    end
endmodule
